//--- lpc_map.svh
/*
  Register offsets, field positions, reset values and timing constants for
  the LED dimming core. Assumes byte-wide register access from a serial
  engine on the same clock.
*/
// Functional notes
// - 8-bit width: duty comes from the low byte, high byte ignored.
// - Duty bytes held until zero written to commit, with pin high and awake.
// - Each output owns scale A then scale B at consecutive addresses.
// - Scale writes act at once, with no commit needed.
// - Peak code is global current times scale sum over 512.
// - Phase register bit 7 enables six-group phase delay.
// - Each phase choice bit selects 0 or 180 degrees for its group.
// - Writing detect mode 10 or 11 runs one short or open pass.
// - Fault flags hold only the latest pass type, replacing older contents.
// - A fault flag reads 1 when that output has the fault.
// - Overtemperature flag reads 1 above the roll-off threshold.
// - Derate field scales current to 100, 75, 55 or 30 percent.
// - Threshold field sets the roll-off temperature; code 00 is 140 C.
// - Three full-on bits each govern six channels; polarity is a parameter.
// - Register-driven duty spans zero to N-1 over N of the period.
// - Full-on outputs stay on all period regardless of duty.
// - Spread enable bit turns oscillator spreading on or off.
// - Spread period field selects 1980, 1200, 820 or 660 us.
// - Spread range field selects 5, 15, 24 or 34 percent deviation.
// - Average current follows the two duty values summed over twice N.
// - Width field selects 8, 10, 12 or 16 bit resolution.
// - Each output owns four duty bytes from address 4n-3.
`ifndef LPC_MAP_SVH
`define LPC_MAP_SVH

`define LPC_A_DUTY_FIRST 8'h01
`define LPC_A_DUTY_LAST 8'h48
`define LPC_A_COMMIT 8'h49
`define LPC_A_SCALE_FIRST 8'h4a
`define LPC_A_SCALE_LAST 8'h6d
`define LPC_A_GCC 8'h6e
`define LPC_A_PHASE 8'h70
`define LPC_A_FDET 8'h71
`define LPC_A_FST_FIRST 8'h72
`define LPC_A_FST_LAST 8'h76
`define LPC_A_THERM 8'h77
`define LPC_A_SPREAD 8'h78

`define LPC_COMMIT_KEY 8'h00
`define LPC_RST_BYTE 8'h00
`define LPC_PHASE_ON_BIT 7
`define LPC_THERM_DERATE_LSB 6
`define LPC_THERM_FLAG_BIT 4
`define LPC_FULLON_LSB 5
`define LPC_SPREAD_EN_BIT 4
`define LPC_SPREAD_RNG_LSB 2

`define LPC_DERATE_F0 8'h80
`define LPC_DERATE_F1 8'h60
`define LPC_DERATE_F2 8'h46
`define LPC_DERATE_F3 8'h26

`define LPC_MCLK_MHZ 200
`define LPC_SPREAD_T0_US 1980
`define LPC_SPREAD_T1_US 1200
`define LPC_SPREAD_T2_US 820
`define LPC_SPREAD_T3_US 660

`endif

//--- lpc_pkg.sv
/*
  Types shared by the LED dimming core. Assumes lpc_map.svh for numbers.
*/
package lpc_pkg;
  typedef logic [7:0] lpc_byte_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lpc_req_t;
  typedef struct packed {
    logic en;
    logic [1:0] range;
    logic [1:0] period;
    logic sweep_up;
  } lpc_spread_t;
  typedef enum logic [1:0] {LPC_W8, LPC_W10, LPC_W12, LPC_W16} lpc_width_t;
endpackage

//--- lpc_core.sv
/*
  LED dimming core: duty shadow and commit, per-channel scaling, global
  current, phase delay, full-on override, fault capture, thermal derate and
  spread control. Assumes a serial engine on mclk presenting one-cycle
  register requests, and analog sense inputs from outside the clock domain.
*/
`timescale 1ns/10ps
`include "lpc_map.svh"

module lpc_core
  import lpc_pkg::*;
#(
  parameter int CHANNELS = 18,
  parameter logic FULLON_LEVEL = 1'b0,
  parameter int SPREAD_P0_CYC = `LPC_SPREAD_T0_US * `LPC_MCLK_MHZ,
  parameter int SPREAD_P1_CYC = `LPC_SPREAD_T1_US * `LPC_MCLK_MHZ,
  parameter int SPREAD_P2_CYC = `LPC_SPREAD_T2_US * `LPC_MCLK_MHZ,
  parameter int SPREAD_P3_CYC = `LPC_SPREAD_T3_US * `LPC_MCLK_MHZ
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register access
  input wire lpc_req_t reg_req,
  output lpc_byte_t rd_data,
  output logic rd_valid,
  // Control bits held elsewhere
  input wire logic soft_sleep_n,
  input wire logic [1:0] pwm_width_sel,
  // Pins and analog sense
  input wire logic shutdown_pin_n,
  input wire logic temp_hot,
  input wire logic [17:0] open_sense,
  input wire logic [17:0] short_sense,
  // LED drive and analog settings
  output logic [17:0] led_on,
  output logic [17:0][7:0] current_code,
  output logic [1:0] rolloff_threshold,
  output lpc_spread_t spread_ctrl
);
  localparam int NDUTY = 4 * CHANNELS;
  localparam int NSCALE = 2 * CHANNELS;

  // Reset release and input synchronisers
  logic rst_meta, rst_sync_n;
  logic [37:0] sync1, sync2;
  logic sd_s, hot_s;
  logic [17:0] open_s, short_s;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {shutdown_pin_n, temp_hot, open_sense, short_sense};
      sync2 <= sync1;
    end
  end
  assign {sd_s, hot_s, open_s, short_s} = sync2;

  // Register file
  lpc_byte_t shadow [NDUTY];
  lpc_byte_t active [NDUTY];
  lpc_byte_t scale [NSCALE];
  lpc_byte_t global_current_level, phase_reg, spread_reg;
  logic [1:0] mode, derate, thresh;
  logic [17:0] fault;
  lpc_byte_t next_shadow [NDUTY];
  lpc_byte_t next_active [NDUTY];
  lpc_byte_t next_scale [NSCALE];
  lpc_byte_t next_gcc, next_phase, next_spread;
  logic [1:0] next_mode, next_derate, next_thresh;
  logic [17:0] next_fault;
  lpc_byte_t duty_off, scale_off;
  logic commit_hit, commit_go, run;

  assign duty_off = reg_req.addr - `LPC_A_DUTY_FIRST;
  assign scale_off = reg_req.addr - `LPC_A_SCALE_FIRST;
  assign commit_hit = reg_req.wr && reg_req.addr == `LPC_A_COMMIT;
  assign commit_go = commit_hit && reg_req.wdata == `LPC_COMMIT_KEY
                     && sd_s && soft_sleep_n;
  assign run = sd_s && soft_sleep_n;

  always_comb begin
    next_shadow = shadow;
    next_active = active;
    next_scale = scale;
    next_gcc = global_current_level;
    next_phase = phase_reg;
    next_spread = spread_reg;
    next_mode = mode;
    next_derate = derate;
    next_thresh = thresh;
    next_fault = fault;
    if (reg_req.wr) begin
      if (reg_req.addr >= `LPC_A_DUTY_FIRST && reg_req.addr <= `LPC_A_DUTY_LAST)
        next_shadow[duty_off[6:0]] = reg_req.wdata;
      if (reg_req.addr >= `LPC_A_SCALE_FIRST && reg_req.addr <= `LPC_A_SCALE_LAST)
        next_scale[scale_off[5:0]] = reg_req.wdata;
      case (reg_req.addr)
        `LPC_A_GCC: next_gcc = reg_req.wdata;
        `LPC_A_PHASE: next_phase = reg_req.wdata & 8'hbf;
        `LPC_A_SPREAD: next_spread = reg_req.wdata;
        `LPC_A_THERM: begin
          next_derate = reg_req.wdata[`LPC_THERM_DERATE_LSB +: 2];
          next_thresh = reg_req.wdata[1:0];
        end
        `LPC_A_FDET: begin
          next_mode = reg_req.wdata[1:0];
          // One pass per write, replacing the previous type
          if (reg_req.wdata[1])
            next_fault = reg_req.wdata[0] ? open_s : short_s;
        end
        default: ;
      endcase
    end
    if (commit_go) begin
      for (int i = 0; i < NDUTY; i++)
        next_active[i] = shadow[i];
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      for (int i = 0; i < NDUTY; i++) begin
        shadow[i] <= `LPC_RST_BYTE;
        active[i] <= `LPC_RST_BYTE;
      end
      for (int i = 0; i < NSCALE; i++)
        scale[i] <= `LPC_RST_BYTE;
      global_current_level <= `LPC_RST_BYTE;
      phase_reg <= `LPC_RST_BYTE;
      spread_reg <= `LPC_RST_BYTE;
      mode <= 2'h0;
      derate <= 2'h0;
      thresh <= 2'h0;
      fault <= 18'h00000;
    end else begin
      shadow <= next_shadow;
      active <= next_active;
      scale <= next_scale;
      global_current_level <= next_gcc;
      phase_reg <= next_phase;
      spread_reg <= next_spread;
      mode <= next_mode;
      derate <= next_derate;
      thresh <= next_thresh;
      fault <= next_fault;
    end
  end

  // Read path
  lpc_byte_t next_rd_data, fst_off;
  logic next_rd_valid;

  function automatic lpc_byte_t fault_byte(input logic [17:0] f, input int k);
    lpc_byte_t b;
    b = 8'h00;
    for (int j = 0; j < 4; j++)
      if (4 * k + j < 18)
        b[2 * j] = f[4 * k + j];
    return b;
  endfunction

  assign fst_off = reg_req.addr - `LPC_A_FST_FIRST;

  always_comb begin
    next_rd_valid = reg_req.rd;
    next_rd_data = 8'h00;
    if (reg_req.rd) begin
      if (reg_req.addr >= `LPC_A_DUTY_FIRST && reg_req.addr <= `LPC_A_DUTY_LAST)
        next_rd_data = shadow[duty_off[6:0]];
      else if (reg_req.addr >= `LPC_A_SCALE_FIRST && reg_req.addr <= `LPC_A_SCALE_LAST)
        next_rd_data = scale[scale_off[5:0]];
      else if (reg_req.addr >= `LPC_A_FST_FIRST && reg_req.addr <= `LPC_A_FST_LAST)
        next_rd_data = fault_byte(fault, int'(fst_off[2:0]));
      else begin
        case (reg_req.addr)
          `LPC_A_GCC: next_rd_data = global_current_level;
          `LPC_A_PHASE: next_rd_data = phase_reg;
          `LPC_A_FDET: next_rd_data = {6'h00, mode};
          `LPC_A_THERM: next_rd_data = {derate, 1'b0, hot_s, 2'h0, thresh};
          `LPC_A_SPREAD: next_rd_data = spread_reg;
          default: next_rd_data = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      rd_data <= next_rd_data;
      rd_valid <= next_rd_valid;
    end
  end

  // PWM period counter; even periods use pair A, odd periods pair B
  lpc_width_t width;
  logic [15:0] cnt, next_cnt, mask, half;
  logic pick_b, next_pick_b;
  logic [17:0] next_led;
  logic [17:0][7:0] next_code;
  lpc_byte_t factor;

  assign width = lpc_width_t'(pwm_width_sel);

  always_comb begin
    case (width)
      LPC_W8: mask = 16'h00ff;
      LPC_W10: mask = 16'h03ff;
      LPC_W12: mask = 16'h0fff;
      LPC_W16: mask = 16'hffff;
      default: mask = 16'h00ff;
    endcase
    half = (mask >> 1) + 16'h0001;
  end

  function automatic logic [15:0] duty_of(input lpc_byte_t lo, input lpc_byte_t hi,
                                          input lpc_width_t w);
    case (w)
      LPC_W8: return {8'h00, lo};
      LPC_W10: return {6'h00, hi[1:0], lo};
      LPC_W12: return {4'h0, hi[3:0], lo};
      default: return {hi, lo};
    endcase
  endfunction

  always_comb begin
    logic [15:0] cg, duty;
    logic full;
    cg = 16'h0000;
    duty = 16'h0000;
    full = 1'b0;
    next_cnt = ((cnt & mask) == mask) ? 16'h0000 : (cnt + 16'h0001) & mask;
    next_pick_b = ((cnt & mask) == mask) ? !pick_b : pick_b;
    for (int c = 0; c < CHANNELS; c++) begin
      cg = cnt & mask;
      if (phase_reg[`LPC_PHASE_ON_BIT] && phase_reg[c / 3])
        cg = (cnt + half) & mask;
      if (pick_b)
        duty = duty_of(active[4 * c + 2], active[4 * c + 3], width);
      else
        duty = duty_of(active[4 * c], active[4 * c + 1], width);
      full = spread_reg[`LPC_FULLON_LSB + c / 6] == FULLON_LEVEL;
      // Duty never exceeds N-1, so the last count is dark unless the group is full-on
      next_led[c] = run && (full || cg < duty);
    end
  end

  // Peak current code with thermal derate
  always_comb begin
    case (derate)
      2'h0: factor = `LPC_DERATE_F0;
      2'h1: factor = `LPC_DERATE_F1;
      2'h2: factor = `LPC_DERATE_F2;
      default: factor = `LPC_DERATE_F3;
    endcase
    if (!hot_s)
      factor = `LPC_DERATE_F0;
  end

  always_comb begin
    logic [16:0] prod;
    logic [15:0] der;
    prod = 17'h00000;
    der = 16'h0000;
    for (int c = 0; c < CHANNELS; c++) begin
      prod = 17'(global_current_level) * 17'({1'b0, scale[2 * c]} + {1'b0, scale[2 * c + 1]});
      der = 16'(prod[16:9]) * 16'(factor);
      next_code[c] = der[14:7];
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cnt <= 16'h0000;
      pick_b <= 1'b0;
      led_on <= 18'h00000;
      current_code <= '0;
    end else begin
      cnt <= next_cnt;
      pick_b <= next_pick_b;
      led_on <= next_led;
      current_code <= next_code;
    end
  end

  // Spread modulation sweep: direction flips each half cycle time
  logic [19:0] sweep_cnt, next_sweep_cnt, sweep_last;
  logic sweep_up, next_sweep_up;

  always_comb begin
    case (spread_reg[1:0])
      2'h0: sweep_last = 20'(SPREAD_P0_CYC / 2 - 1);
      2'h1: sweep_last = 20'(SPREAD_P1_CYC / 2 - 1);
      2'h2: sweep_last = 20'(SPREAD_P2_CYC / 2 - 1);
      default: sweep_last = 20'(SPREAD_P3_CYC / 2 - 1);
    endcase
    next_sweep_cnt = 20'h00000;
    next_sweep_up = 1'b0;
    if (spread_reg[`LPC_SPREAD_EN_BIT]) begin
      next_sweep_up = sweep_up;
      next_sweep_cnt = sweep_cnt + 20'h00001;
      if (sweep_cnt >= sweep_last) begin
        next_sweep_cnt = 20'h00000;
        next_sweep_up = !sweep_up;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sweep_cnt <= 20'h00000;
      sweep_up <= 1'b0;
    end else begin
      sweep_cnt <= next_sweep_cnt;
      sweep_up <= next_sweep_up;
    end
  end

  assign spread_ctrl = '{en: spread_reg[`LPC_SPREAD_EN_BIT],
                         range: spread_reg[`LPC_SPREAD_RNG_LSB +: 2],
                         period: spread_reg[1:0],
                         sweep_up: sweep_up};
  assign rolloff_threshold = thresh;

  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_sync_n);

  sequence s_dirty_duty;
    reg_req.wr && reg_req.addr == `LPC_A_DUTY_FIRST;
  endsequence
  sequence s_good_commit;
    commit_hit && reg_req.wdata == `LPC_COMMIT_KEY && sd_s && soft_sleep_n;
  endsequence

  a_commit_copies: assert property (s_good_commit |=> active[0] == $past(shadow[0]))
    else $error("commit did not copy duty byte");
  a_duty_held: assert property (s_dirty_duty ##1 !commit_hit |=> active[0] == $past(active[0], 2))
    else $error("duty byte reached output without commit");
  a_commit_nonzero: assert property (commit_hit && reg_req.wdata != `LPC_COMMIT_KEY
                                     |=> active[0] == $past(active[0]))
    else $error("nonzero commit changed duty");
  a_scale_immediate: assert property (reg_req.wr && reg_req.addr == `LPC_A_SCALE_FIRST + 8'h01
                                      |=> scale[1] == $past(reg_req.wdata))
    else $error("scale B write not applied at once");
  a_full_on: assert property (run && spread_reg[`LPC_FULLON_LSB] == FULLON_LEVEL
                              |=> led_on[0])
    else $error("full-on group not lit");
  a_sleep_dark: assert property (!soft_sleep_n |=> led_on == 18'h00000)
    else $error("outputs lit while asleep");
  a_last_count_dark: assert property (width == LPC_W8 && cnt == 16'h00ff
                                      && !phase_reg[`LPC_PHASE_ON_BIT]
                                      && spread_reg[`LPC_FULLON_LSB] != FULLON_LEVEL
                                      |=> !led_on[0])
    else $error("output lit on last count");
  a_open_capture: assert property (reg_req.wr && reg_req.addr == `LPC_A_FDET
                                   && reg_req.wdata[1:0] == 2'h3
                                   |=> fault == $past(open_s))
    else $error("open pass not captured");
  a_detect_off_keeps: assert property (reg_req.wr && reg_req.addr == `LPC_A_FDET
                                       && !reg_req.wdata[1] |=> $stable(fault))
    else $error("disabled detect changed flags");
  a_temp_flag_read: assert property (reg_req.rd && reg_req.addr == `LPC_A_THERM
                                     |=> rd_valid && rd_data[`LPC_THERM_FLAG_BIT] == $past(hot_s))
    else $error("thermal flag readback wrong");
  a_peak_full: assert property (global_current_level == 8'hff && scale[0] == 8'hff && scale[1] == 8'hff && !hot_s
                                |=> current_code[0] == 8'hfe)
    else $error("peak code wrong at full scale");
endmodule

//--- lpc_led_model.sv
/*
  Far-side model of the LED strings and die temperature sensor for the
  dimming core. Assumes the bench sets the fault pattern and die temperature
  and that the core's sense inputs are sampled through synchronisers.
*/
`timescale 1ns/10ps

module lpc_led_model
  import lpc_pkg::*;
#(
  parameter int T00 = 140,
  parameter int T01 = 150,
  parameter int T10 = 160,
  parameter int T11 = 170
) (
  // Clock
  input wire logic mclk,
  // Scene set by the bench
  input wire logic [17:0] open_pat,
  input wire logic [17:0] short_pat,
  input wire logic [15:0] die_temp,
  // Device side
  input wire logic [1:0] rolloff_threshold,
  output logic temp_hot,
  output logic [17:0] open_sense,
  output logic [17:0] short_sense
);
  int limit;

  // Roll-off start point per threshold code; only code 00 is fixed
  always_comb begin
    case (rolloff_threshold)
      2'h0: limit = T00;
      2'h1: limit = T01;
      2'h2: limit = T10;
      default: limit = T11;
    endcase
  end

  always @(posedge mclk) begin
    temp_hot <= (die_temp > limit);
    open_sense <= open_pat;
    short_sense <= short_pat;
  end
endmodule

//--- test_led_pwm_current_control.sv
/*
  Self-checking bench for the LED dimming core: register access, scaling,
  derate, fault capture, duty commit, phase, full-on and spread control.
  Assumes lpc_core and lpc_led_model; fault and thermal sense come from the model.
*/
`timescale 1ns/10ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("[FAIL] %0t mismatch got %h exp %h", $time, (got), (exp)); end end

module test_led_pwm_current_control
  import lpc_pkg::*;
;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  lpc_req_t reg_req = '0;
  lpc_byte_t rd_data;
  logic rd_valid;
  logic soft_sleep_n = 1'b1;
  logic [1:0] pwm_width_sel = 2'h0;
  logic shutdown_pin_n = 1'b1;
  logic temp_hot;
  logic [17:0] open_sense, short_sense, led_on;
  logic [17:0] open_pat = 18'h00000;
  logic [17:0] short_pat = 18'h00000;
  logic [15:0] die_temp = 16'h0019;
  logic [17:0][7:0] current_code;
  logic [1:0] rolloff_threshold;
  lpc_spread_t spread_ctrl;
  int n_mismatch = 0;
  int checks = 0;
  int c;
  logic last_sweep;
  int per[4] = '{40, 24, 16, 12};
  int fac[4] = '{128, 96, 70, 38};
  logic [7:0] rst_list[9] = '{8'h4a, 8'h6d, 8'h6e, 8'h70, 8'h71, 8'h77, 8'h78, 8'h6f, 8'h7f};

  always #2.5 mclk = ~mclk;

  lpc_core #(.SPREAD_P0_CYC(40), .SPREAD_P1_CYC(24), .SPREAD_P2_CYC(16),
    .SPREAD_P3_CYC(12)) dut_u (.mclk(mclk), .rst_n(rst_n), .reg_req(reg_req),
    .rd_data(rd_data), .rd_valid(rd_valid), .soft_sleep_n(soft_sleep_n),
    .pwm_width_sel(pwm_width_sel), .shutdown_pin_n(shutdown_pin_n),
    .temp_hot(temp_hot), .open_sense(open_sense), .short_sense(short_sense),
    .led_on(led_on), .current_code(current_code),
    .rolloff_threshold(rolloff_threshold), .spread_ctrl(spread_ctrl));

  lpc_led_model far_u (.mclk(mclk), .open_pat(open_pat), .short_pat(short_pat),
    .die_temp(die_temp), .rolloff_threshold(rolloff_threshold),
    .temp_hot(temp_hot), .open_sense(open_sense), .short_sense(short_sense));

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_req <= {1'b1, 1'b0, a, d};
    @(posedge mclk);
    reg_req <= '0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_req <= {1'b0, 1'b1, a, 8'h00};
    @(posedge mclk);
    reg_req <= '0;
    #1;
    `CHK(rd_valid, 1'b1)
    `CHK(rd_data, e)
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Counts on-cycles of output a, or cycles where a and b differ
  task automatic cnt(input int a, input int b, input int n, output int k);
    k = 0;
    repeat (n) begin
      @(posedge mclk);
      #1;
      if (b < 0) k += (led_on[a] === 1'b1);
      else k += (led_on[a] !== led_on[b]);
    end
  endtask

  function automatic logic [7:0] cur(input int g, input int a, input int b, input int f);
    cur = 8'((((g * (a + b)) >> 9) * f) >> 7);
  endfunction

  function automatic logic [7:0] fbyte(input logic [17:0] p, input int j);
    fbyte = 8'h00;
    for (int i = 0; i < 4; i++)
      if (4 * j + i < 18) fbyte[2 * i] = p[4 * j + i];
  endfunction

  task automatic finish_test();
    if (n_mismatch == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    n_mismatch++;
    finish_test();
  end

  initial begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    wr(8'h77, 8'h00);
    foreach (rst_list[i]) rd_chk(rst_list[i], 8'h00);
    `CHK(led_on, 18'h3ffff)
    // Scaling acts without commit
    wr(8'h6e, 8'hff);
    wr(8'h4c, 8'h80);
    wr(8'h4d, 8'h40);
    idle(3);
    `CHK(current_code[1], cur(255, 128, 64, 128))
    `CHK(current_code[0], 8'h00)
    rd_chk(8'h4d, 8'h40);
    // Full scale on output one
    wr(8'h4a, 8'hff);
    wr(8'h4b, 8'hff);
    idle(3);
    `CHK(current_code[0], cur(255, 255, 255, 128))
    // Thermal derate while hot
    @(posedge mclk);
    die_temp <= 16'h0091;
    idle(6);
    for (int d = 0; d < 4; d++) begin
      wr(8'h77, {2'(d), 6'h00});
      idle(3);
      `CHK(current_code[1], cur(255, 128, 64, fac[d]))
    end
    wr(8'h77, 8'h40);
    rd_chk(8'h77, 8'h50);
    wr(8'h77, 8'h41);
    idle(6);
    `CHK(rolloff_threshold, 2'h1)
    rd_chk(8'h77, 8'h41);
    `CHK(current_code[1], cur(255, 128, 64, 128))
    // Fault capture, open then short, then disabled codes
    open_pat <= 18'h2a5c3;
    short_pat <= 18'h15a3c;
    wr(8'h6e, 8'h01);
    idle(4);
    wr(8'h71, 8'h03);
    for (int j = 0; j < 5; j++) rd_chk(8'h72 + 8'(j), fbyte(18'h2a5c3, j));
    wr(8'h71, 8'h02);
    for (int j = 0; j < 5; j++) rd_chk(8'h72 + 8'(j), fbyte(18'h15a3c, j));
    open_pat <= 18'h3ffff;
    short_pat <= 18'h00000;
    idle(4);
    wr(8'h71, 8'h00);
    wr(8'h71, 8'h01);
    for (int j = 0; j < 5; j++) rd_chk(8'h72 + 8'(j), fbyte(18'h15a3c, j));
    // Full-on groups and duty commit
    wr(8'h78, 8'hc0);
    idle(3);
    `CHK(led_on, 18'h0003f)
    wr(8'h78, 8'he0);
    idle(3);
    `CHK(led_on, 18'h00000)
    wr(8'h01, 8'h40);
    wr(8'h02, 8'hff);
    wr(8'h03, 8'h40);
    wr(8'h04, 8'hff);
    for (int a = 5; a < 9; a++) wr(8'(a), 8'hff);
    for (int a = 9; a < 17; a++) wr(8'(a), a[0] ? 8'h80 : 8'h00);
    cnt(0, -1, 512, c);
    `CHK(c, 0)
    wr(8'h49, 8'h01);
    cnt(0, -1, 512, c);
    `CHK(c, 0)
    @(posedge mclk);
    shutdown_pin_n <= 1'b0;
    idle(4);
    wr(8'h49, 8'h00);
    @(posedge mclk);
    shutdown_pin_n <= 1'b1;
    soft_sleep_n <= 1'b0;
    idle(4);
    wr(8'h49, 8'h00);
    @(posedge mclk);
    soft_sleep_n <= 1'b1;
    cnt(0, -1, 512, c);
    `CHK(c, 0)
    wr(8'h49, 8'h00);
    idle(4);
    cnt(0, -1, 512, c);
    `CHK(c, 128)
    cnt(1, -1, 512, c);
    `CHK(c, 510)
    // Phase: outputs 3 and 4 sit in groups 0 and 1 at half duty
    cnt(2, 3, 256, c);
    `CHK(c, 0)
    wr(8'h70, 8'h01);
    idle(4);
    cnt(2, 3, 256, c);
    `CHK(c, 0)
    wr(8'h70, 8'h81);
    idle(4);
    cnt(2, 3, 256, c);
    `CHK(c, 256)
    wr(8'h70, 8'h83);
    idle(4);
    cnt(2, 3, 256, c);
    `CHK(c, 0)
    wr(8'h70, 8'hff);
    rd_chk(8'h70, 8'hbf);
    // 10-bit width uses the high byte
    @(posedge mclk);
    pwm_width_sel <= 2'h1;
    wr(8'h02, 8'h01);
    wr(8'h04, 8'h01);
    wr(8'h01, 8'h00);
    wr(8'h03, 8'h00);
    wr(8'h49, 8'h00);
    idle(1030);
    cnt(0, -1, 2048, c);
    `CHK(c, 512)
    // 12-bit width takes four bits of the high byte
    @(posedge mclk);
    pwm_width_sel <= 2'h2;
    wr(8'h02, 8'h05);
    wr(8'h04, 8'h05);
    wr(8'h49, 8'h00);
    idle(4);
    cnt(0, -1, 4096, c);
    `CHK(c, 1280)
    // Spread fields
    for (int k = 0; k < 4; k++) begin
      wr(8'h78, {4'hf, 2'(k), 2'(3 - k)});
      idle(2);
      `CHK(spread_ctrl.en, 1'b1)
      `CHK(spread_ctrl.range, 2'(k))
      `CHK(spread_ctrl.period, 2'(3 - k))
      // Sweep direction flips every half cycle time
      last_sweep = spread_ctrl.sweep_up;
      c = 0;
      repeat (240) begin
        @(posedge mclk);
        #1;
        c += (spread_ctrl.sweep_up !== last_sweep);
        last_sweep = spread_ctrl.sweep_up;
      end
      `CHK(c, 480 / per[3 - k])
    end
    wr(8'h78, 8'he0);
    idle(2);
    `CHK(spread_ctrl.en, 1'b0)
    `CHK(spread_ctrl.sweep_up, 1'b0)
    finish_test();
  end
endmodule
